// File: asrc_host.sv
/*
 * Host controller for an asynchronous 64K x 4 static memory.
 * Assumes requests synchronous to i_mclk and a board that resolves the
 * shared data wires from o_dq_out and o_dq_oe_b.
 */
// Functional notes
// - Write happens only while all enabled selects and write strobe are low.
// - Write ends when any select or the strobe rises first.
// - Memory captures data at write-ending edge; host holds data around it.
// - Host keeps write strobe high during every read.
// - Host presents address no later than selects fall.
// - Strobe write with gate low lasts float delay plus data set-up.
// - Host may hold output gate high for the whole strobe write.
`timescale 1ns/1ps
`default_nettype none
`include "asrc_defines.svh"
module asrc_host import asrc_pkg::*; #(
  parameter int AW      = 16,
  parameter int DW      = 4,
  parameter int VARIANT = `ASRC_VAR_TWO_CS_OE,
  parameter bit GATE_HIGH_ON_WRITE = 1'b1
) (
  // Clock and reset
  input  wire logic          i_mclk,
  input  wire logic          i_rst_b,
  // User request
  input  wire logic          i_req,
  input  wire logic          i_wr,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  // User answer
  output logic               o_busy,
  output logic               o_done,
  output logic [DW-1:0]      o_rdata,
  // Memory pins
  output logic [AW-1:0]      o_mem_addr,
  output logic               o_cs1_b,
  output logic               o_cs2_b,
  output logic               o_we_b,
  output logic               o_oe_b,
  output logic [DW-1:0]      o_dq_out,
  output logic [DW-1:0]      o_dq_oe_b,
  input  wire logic [DW-1:0] i_dq_in
);
  localparam int TW = 4;
  localparam logic [TW-1:0] SETUP_CYC = TW'(`ASRC_SETUP_CYC);
  localparam logic [TW-1:0] WRITE_CYC = TW'(`ASRC_WRITE_CYC);
  localparam logic [TW-1:0] READ_CYC  = TW'(`ASRC_READ_CYC);
  localparam bit HAS_OE  = (VARIANT != `ASRC_VAR_ONE_CS);
  localparam bit HAS_CS2 = (VARIANT == `ASRC_VAR_TWO_CS_OE);

  // ****************************************
  // Sequence state
  // ****************************************
  asrc_state_e state, next_state;
  logic              wr, next_wr;
  logic [AW-1:0]     addr, next_addr;
  logic [DW-1:0]     wdata, next_wdata;
  logic [DW-1:0]     rdata, next_rdata;
  logic              cs_b, next_cs_b;
  logic              we_b, next_we_b;
  logic              oe_b, next_oe_b;
  logic              drive, next_drive;
  logic              done, next_done;
  logic              busy, next_busy;
  logic [DW-1:0]     dq_oe_b, next_dq_oe_b;
  logic              t_load;
  logic [TW-1:0]     t_value;
  logic              t_done;

  asrc_timer #(.W(TW)) u_timer (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_load  (t_load),
    .i_value (t_value),
    .o_done  (t_done)
  );

  // Next values of the access sequence
  always_comb begin
    next_state = state;
    next_wr    = wr;
    next_addr  = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_cs_b  = cs_b;
    next_we_b  = we_b;
    next_oe_b  = oe_b;
    next_drive = drive;
    next_done  = 1'b0;
    t_load     = 1'b0;
    t_value    = SETUP_CYC;
    unique case (state)
      ASRC_IDLE: begin
        if (i_req) begin
          // Address settles while still deselected, ahead of the select edge
          next_addr  = i_addr;
          next_wr    = i_wr;
          next_wdata = i_wdata;
          t_load     = 1'b1;
          t_value    = SETUP_CYC;
          next_state = ASRC_SETUP;
        end
      end
      ASRC_SETUP: begin
        if (t_done) begin
          next_cs_b = 1'b0;
          t_load    = 1'b1;
          if (wr) begin
            // Gate held high so the memory never drives during the write
            next_oe_b  = GATE_HIGH_ON_WRITE ? 1'b1 : 1'b0;
            next_we_b  = 1'b0;
            next_drive = 1'b1;
            // A load of n keeps the state n+1 cycles; strobe low the write time
            t_value    = WRITE_CYC - TW'(1);
            next_state = ASRC_WRITE;
          end else begin
            next_we_b  = 1'b1;
            next_oe_b  = 1'b0;
            t_value    = READ_CYC;
            next_state = ASRC_READ;
          end
        end
      end
      ASRC_WRITE: begin
        if (t_done) begin
          // Strobe ends the write, data still held; the gate rises with it so
          // the memory cannot drive against our data in the next cycle
          next_we_b  = 1'b1;
          next_oe_b  = 1'b1;
          // No gate pin: the select rises with the strobe to keep pins quiet
          if (!HAS_OE) begin
            next_cs_b = 1'b1;
          end
          next_state = ASRC_END;
        end
      end
      ASRC_READ: begin
        if (t_done) begin
          next_rdata = i_dq_in;
          next_oe_b  = 1'b1;
          next_cs_b  = 1'b1;
          next_done  = 1'b1;
          next_state = ASRC_IDLE;
        end
      end
      ASRC_END: begin
        // Data released one cycle after the strobe edge for hold margin
        next_drive = 1'b0;
        next_cs_b  = 1'b1;
        next_oe_b  = 1'b1;
        next_done  = 1'b1;
        next_state = ASRC_IDLE;
      end
    endcase
    // Outputs leave flops, so their values are formed from the next state
    next_busy    = (next_state != ASRC_IDLE);
    next_dq_oe_b = {DW{~next_drive}};
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ASRC_IDLE;
      wr    <= 1'b0;
      addr  <= '0;
      wdata <= '0;
      rdata <= '0;
      cs_b  <= 1'b1;
      we_b  <= 1'b1;
      oe_b  <= 1'b1;
      drive <= 1'b0;
      done  <= 1'b0;
      busy  <= 1'b0;
      dq_oe_b <= '1;
    end else begin
      state <= next_state;
      wr    <= next_wr;
      addr  <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      cs_b  <= next_cs_b;
      we_b  <= next_we_b;
      oe_b  <= next_oe_b;
      drive <= next_drive;
      done  <= next_done;
      busy  <= next_busy;
      dq_oe_b <= next_dq_oe_b;
    end
  end

  // ****************************************
  // Pin mapping
  // ****************************************
  // Unused select and gate stay inactive on smaller variants
  assign o_mem_addr = addr;
  assign o_cs1_b    = cs_b;
  assign o_cs2_b    = HAS_CS2 ? cs_b : 1'b1;
  assign o_we_b     = we_b;
  assign o_oe_b     = HAS_OE ? oe_b : 1'b1;
  assign o_dq_out   = wdata;
  assign o_dq_oe_b  = dq_oe_b;
  assign o_rdata    = rdata;
  assign o_done     = done;
  assign o_busy     = busy;

  // ****************************************
  // Checks
  // ****************************************
  strobe_high_read_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (state == ASRC_READ) |-> o_we_b)
    else $error("write strobe low during read");
  write_needs_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !o_we_b |-> !o_cs1_b && (!HAS_CS2 || !o_cs2_b))
    else $error("strobe low without select");
  write_length_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $fell(o_we_b) |-> !o_we_b [*2] ##1 o_we_b)
    else $error("write strobe length wrong");
  strobe_ends_first_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $rose(o_we_b) |-> (!o_cs1_b || !HAS_OE) && o_dq_oe_b == '0)
    else $error("strobe not first to end write");
  data_held_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $rose(o_we_b) |-> $stable(o_dq_out) ##1 $stable(o_dq_out))
    else $error("write data moved at write end");
  addr_before_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $fell(o_cs1_b) |-> $stable(o_mem_addr))
    else $error("address changed at select edge");
  gate_high_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!o_we_b && GATE_HIGH_ON_WRITE) |-> o_oe_b)
    else $error("output gate low during write");
  deselect_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_done |-> o_cs1_b && o_cs2_b && o_dq_oe_b == '1)
    else $error("memory left selected after access");
endmodule : asrc_host
`default_nettype wire

// File: asrc_defines.svh
/*
 * Timing constants and variant codes for the asynchronous static memory
 * host controller. Assumes a 50 MHz controller clock (20 ns period).
 */
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH

// Controller clock period in ns
`define ASRC_CLK_NS          20
// Address set-up before strobe, ns (least)
`define ASRC_ADDR_SETUP_NS   20
// Strobe low time, ns (least)
`define ASRC_STROBE_NS       40
// Strobe to data float delay, ns (longest the memory may take)
`define ASRC_FLOAT_NS        20
// Write data set-up before write end, ns (least)
`define ASRC_DATA_SETUP_NS   20
// Read access from select, ns (least wait before sampling)
`define ASRC_READ_NS         40
// Cycle counts, least times rounded up, none below one
`define ASRC_CYC(ns) ((((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS) < 1 ? 1 : \
                      (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS))
`define ASRC_SETUP_CYC  `ASRC_CYC(`ASRC_ADDR_SETUP_NS)
`define ASRC_WRITE_CYC  `ASRC_CYC(`ASRC_FLOAT_NS + `ASRC_DATA_SETUP_NS)
`define ASRC_READ_CYC   `ASRC_CYC(`ASRC_READ_NS)
// Variant codes
`define ASRC_VAR_ONE_CS      0
`define ASRC_VAR_ONE_CS_OE   1
`define ASRC_VAR_TWO_CS_OE   2

`endif

// File: asrc_pkg.sv
/*
 * Types for the asynchronous static memory host controller.
 * Assumes nothing beyond the defines header.
 */
package asrc_pkg;
  // Controller sequence states, one-hot
  typedef enum logic [4:0] {
    ASRC_IDLE  = 5'b00001,
    ASRC_SETUP = 5'b00010,
    ASRC_WRITE = 5'b00100,
    ASRC_READ  = 5'b01000,
    ASRC_END   = 5'b10000
  } asrc_state_e;
endpackage : asrc_pkg

// File: asrc_timer.sv
/*
 * Down counter that times the set-up, write and read phases of a memory access.
 * Assumes a synchronous load and a single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module asrc_timer #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  // Status
  output logic              o_done
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // Load wins over counting; saturate at zero
  always_comb begin
    next_count = count;
    if (i_load) begin
      next_count = i_value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Looks at the count only, so a caller that loads on done forms no loop
  assign o_done = (count == '0);
endmodule : asrc_timer
`default_nettype wire

// File: asrc_mem_model.sv
/*
 * Behavioural 64K x 4 static memory with two selects and an output gate.
 * Assumes the host data pins arrive split into value and enable.
 */
`timescale 1ns/1ps
`default_nettype none
module asrc_mem_model (
  // Control pins
  input  wire logic [15:0] i_addr,
  input  wire logic        i_cs1_b,
  input  wire logic        i_cs2_b,
  input  wire logic        i_we_b,
  input  wire logic        i_oe_b,
  // Host side of the data wires
  input  wire logic [3:0]  i_host_q,
  input  wire logic [3:0]  i_host_oe_b,
  // Resolved wires and contention flag
  output logic [3:0]       o_wire,
  output logic             o_clash
);
  logic [3:0] mem [0:65535];
  logic       tog = 1'b0;
  logic       sel;
  logic       wr_on;
  logic       drive;
  // Any select high deselects and floats the pins
  assign sel   = !i_cs1_b && !i_cs2_b;
  assign wr_on = sel && !i_we_b;
  assign drive = sel && i_we_b && !i_oe_b;
  // Floating wires wander, so stale data never passes for a match
  always #7 tog = ~tog;
  // Store the wires at the edge that ends the overlap
  always @(negedge wr_on) mem[i_addr] = o_wire;
  // Resolve each wire from both parties
  always_comb begin
    o_clash = drive && (i_host_oe_b != 4'hf);
    for (int i = 0; i < 4; i++) begin
      if (!i_host_oe_b[i]) o_wire[i] = i_host_q[i];
      else if (drive) o_wire[i] = mem[i_addr][i];
      else o_wire[i] = tog ^ i_addr[i];
    end
  end
endmodule : asrc_mem_model
`default_nettype wire

// File: tb.sv
/*
 * Self-checking bench for the static memory host controller.
 * Assumes the memory model file; runs the two-select host and a one-select
 * host that keeps its gate low during writes side by side.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_mclk, i_rst_b, i_req, i_wr, o_busy, o_done, clash;
  logic o_cs1_b, o_cs2_b, o_we_b, o_oe_b, pcs;
  logic [15:0] i_addr, o_mem_addr, pa;
  logic [3:0]  i_wdata, o_rdata, o_dq_out, o_dq_oe_b, wire_q;
  // Second host: one select with gate, gate kept low across writes
  logic        b_busy, b_done, b_cs1_b, b_cs2_b, b_we_b, b_oe_b, b_clash, b_pcs;
  logic [15:0] b_mem_addr, b_pa;
  logic [3:0]  b_rdata, b_dq_out, b_dq_oe_b, b_wire;
  logic [31:0] seed = 32'h14;
  logic [31:0] r;
  logic [3:0]  refm [0:65535];
  bit          known [0:65535];
  int          fails = 0, comparisons = 0, wl = 0;
  logic [15:0] used [$];

  asrc_host #(.VARIANT(2)) dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(i_req), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done),
    .o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .o_cs1_b(o_cs1_b),
    .o_cs2_b(o_cs2_b), .o_we_b(o_we_b), .o_oe_b(o_oe_b),
    .o_dq_out(o_dq_out), .o_dq_oe_b(o_dq_oe_b), .i_dq_in(wire_q));
  asrc_mem_model mem (
    .i_addr(o_mem_addr), .i_cs1_b(o_cs1_b), .i_cs2_b(o_cs2_b),
    .i_we_b(o_we_b), .i_oe_b(o_oe_b), .i_host_q(o_dq_out),
    .i_host_oe_b(o_dq_oe_b), .o_wire(wire_q), .o_clash(clash));
  asrc_host #(.VARIANT(1), .GATE_HIGH_ON_WRITE(1'b0)) dut_b (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_req(i_req), .i_wr(i_wr),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(b_busy), .o_done(b_done),
    .o_rdata(b_rdata), .o_mem_addr(b_mem_addr), .o_cs1_b(b_cs1_b),
    .o_cs2_b(b_cs2_b), .o_we_b(b_we_b), .o_oe_b(b_oe_b),
    .o_dq_out(b_dq_out), .o_dq_oe_b(b_dq_oe_b), .i_dq_in(b_wire));
  // Its memory has a single select, so the second select pin is held active
  asrc_mem_model mem_b (
    .i_addr(b_mem_addr), .i_cs1_b(b_cs1_b), .i_cs2_b(1'b0),
    .i_we_b(b_we_b), .i_oe_b(b_oe_b), .i_host_q(b_dq_out),
    .i_host_oe_b(b_dq_oe_b), .o_wire(b_wire), .o_clash(b_clash));

  // Xorshift source, fixed start for repeatable runs
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Expected read value from the bench's own copy
  function automatic logic [3:0] exp_rd(input logic [15:0] a);
    return known[a] ? refm[a] : 4'h0;
  endfunction : exp_rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // One access; caller stands just after a clock edge
  task automatic acc(input logic wr, input logic [15:0] a, input logic [3:0] d);
    int n;
    i_req = 1'b1; i_wr = wr; i_addr = a; i_wdata = d;
    while (o_busy === 1'b1) begin @(posedge i_mclk); #1; end
    @(posedge i_mclk); #1;
    r = xs();
    i_req = 1'b0; i_addr = r[15:0]; i_wdata = r[19:16];  // Inputs only count at the take
    n = 0;
    while (o_done !== 1'b1 && n < 20) begin @(posedge i_mclk); #1; n++; end
    chk(n, 5);
    chk(b_done, 1'b1);
    if (wr) begin
      refm[a] = d;
      known[a] = 1'b1;
    end else begin
      chk(o_rdata, exp_rd(a));
      chk(b_rdata, exp_rd(a));
    end
  endtask : acc
  task automatic idle_chk();
    chk({o_cs1_b, o_cs2_b, o_we_b, o_oe_b, o_dq_oe_b, o_done, o_busy}, 10'h3fc);
    chk({b_cs1_b, b_cs2_b, b_we_b, b_oe_b, b_dq_oe_b, b_done, b_busy}, 10'h3fc);
  endtask : idle_chk

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Pin watcher: contention, address hold, strobe during reads, strobe length.
  // Sampled mid-cycle so it never races the edge that moves the pins.
  always @(negedge i_mclk) begin
    if (!i_rst_b) wl = 0;
    else begin
      chk(clash, 1'b0);
      chk(b_clash, 1'b0);
      if (!o_cs1_b && !pcs) chk(o_mem_addr, pa);
      if (!b_cs1_b && !b_pcs) chk(b_mem_addr, b_pa);
      if (!o_cs1_b && !o_oe_b) chk(o_we_b, 1'b1);
      if (!o_we_b) wl++;
      else begin
        if (wl != 0) chk(wl >= 2, 1'b1);
        wl = 0;
      end
    end
    pcs = o_cs1_b;
    pa = o_mem_addr;
    b_pcs = b_cs1_b;
    b_pa = b_mem_addr;
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end

  initial begin
    i_rst_b = 1'b0; i_req = 1'b0; i_wr = 1'b0; i_addr = 16'h0; i_wdata = 4'h0;
    repeat (2) @(posedge i_mclk);
    #1 i_rst_b = 1'b1;
    idle_chk();
    // Corner addresses and data, overwrite, back-to-back read after write
    acc(1'b1, 16'h0000, 4'h0);
    acc(1'b1, 16'hffff, 4'hf);
    acc(1'b1, 16'h0001, 4'ha);
    acc(1'b1, 16'h0001, 4'h5);
    acc(1'b0, 16'h0001, 4'h0);
    acc(1'b0, 16'hffff, 4'h0);
    acc(1'b0, 16'h0000, 4'h0);
    // Read data stands across a later write
    acc(1'b1, 16'h1234, 4'hc);
    chk(o_rdata, exp_rd(16'h0000));
    chk(b_rdata, exp_rd(16'h0000));
    // Random writes then random-order read back
    for (int k = 0; k < 40; k++) begin
      r = xs();
      acc(1'b1, r[15:0], r[23:20]);
      used.push_back(r[15:0]);
    end
    for (int k = 0; k < 40; k++) begin
      r = xs();
      acc(1'b0, used[r[31:8] % 40], 4'h0);
    end
    // Reset in mid-write drops every pin to idle
    i_req = 1'b1; i_wr = 1'b1; i_addr = 16'h4321; i_wdata = 4'h9;
    @(posedge i_mclk); #1;
    i_req = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 i_rst_b = 1'b0;
    #1 idle_chk();
    @(posedge i_mclk); #1 i_rst_b = 1'b1;
    acc(1'b0, 16'hffff, 4'h0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
